// ---- nph_pkg.sv ----
package nph_pkg;
  // Bus timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int T_STROBE_LOW_NS    = 30;
  localparam int T_STROBE_HIGH_NS   = 20;
  localparam int T_ADL_NS           = 100;
  localparam int T_WHR_NS           = 60;
  localparam int T_WB_NS            = 100;
  localparam int PAGE_TRANSFER_TIME_US = 25;
  // Least times round up, the longest time rounds down
  localparam int LOW_CYC  = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC = (T_STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADL_CYC  = (T_ADL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHR_CYC  = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC   = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TR_CYC   = (PAGE_TRANSFER_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int TMR_W    = 12;

  // Command codes
  localparam logic [7:0] CMD_READ1   = 8'h00;
  localparam logic [7:0] CMD_READ2   = 8'h30;
  localparam logic [7:0] CMD_RND_OUT1 = 8'h05;
  localparam logic [7:0] CMD_RND_OUT2 = 8'he0;
  localparam logic [7:0] CMD_ID      = 8'h90;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_LOAD    = 8'h80;
  localparam logic [7:0] CMD_RND_IN  = 8'h85;
  localparam logic [7:0] CMD_PROG    = 8'h10;
  localparam logic [7:0] ID_ADDR     = 8'h00;

  // Geometry and counts
  localparam int COL_W       = 12;
  localparam int ROW_W       = 18;
  localparam int PAGE_BITS   = 6;
  localparam logic [2:0] ADDR_FULL = 3'h5;
  localparam logic [2:0] ADDR_COL  = 3'h2;
  localparam logic [2:0] ADDR_ID   = 3'h1;
  localparam logic [11:0] ID_BYTES = 12'h004;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  localparam int ST_PASS_BIT = 0;

  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_RAND_OUT = 3'h1,
    OP_ID       = 3'h2,
    OP_STATUS   = 3'h3,
    OP_LOAD     = 3'h4,
    OP_RAND_IN  = 3'h5,
    OP_CONFIRM  = 3'h6,
    OP_NONE     = 3'h7
  } nph_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD1  = 3'b001,
    ST_ADDR  = 3'b011,
    ST_WDATA = 3'b010,
    ST_CMD2  = 3'b110,
    ST_BUSY  = 3'b111,
    ST_RDATA = 3'b101
  } nph_state_t;

  typedef enum logic [1:0] {
    PH_GAP  = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b11
  } nph_phase_t;
endpackage

// ---- nph_timer.sv ----
`timescale 1ns/1ps
module nph_timer #(
  parameter int W = 12
) (
  input  wire logic         clk,      // Core clock
  input  wire logic         resetn,   // Async reset, active low
  input  wire logic         load,     // Load a new count
  input  wire logic [W-1:0] load_val, // Cycles minus one
  output logic              done      // Count has reached zero
);
  logic [W-1:0] cnt_reg;

  // Down counter, parks at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign done = (cnt_reg == '0);
endmodule

// ---- nph_fifo.sv ----
`timescale 1ns/1ps
module nph_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,       // Core clock
  input  wire logic         resetn,    // Async reset, active low
  input  wire logic         in_valid,  // Write side offers a word
  output logic              in_ready,  // Room in the store
  input  wire logic [W-1:0] in_data,   // Word to store
  output logic              out_valid, // Output register holds a word
  input  wire logic         out_ready, // Drain side takes it
  output logic [W-1:0]      out_data   // Registered head word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0]   cnt_reg;
  logic          ov_reg;
  logic [W-1:0]  od_reg;
  wire           push = in_valid && in_ready;
  wire           fill = (cnt_reg != '0) && (!ov_reg || out_ready);

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = ov_reg;
  assign out_data  = od_reg;

  // Storage array has no reset, so it maps onto plain memory
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // Pointers, fill level and the output register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
      ov_reg   <= 1'b0;
      od_reg   <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (fill) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
        od_reg   <= mem[rptr_reg];
        ov_reg   <= 1'b1;
      end else if (out_ready) begin
        ov_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(fill);
    end
  end
endmodule

// ---- nph_host.sv ----
// Function
// [R1] Chip enable may drop during data gaps
// [R2] Address: two column then three row bytes
// [R3] Command 90h returns four identification bytes
// [R4] Fourth ID byte bits give page, block size
// [R5] Fourth ID byte gives spare, width, speed
// [R6] Page read is 00h, five addresses, 30h
// [R7] After power-up 00h is already latched
// [R8] Page moves to register within 25 us
// [R9] Each read strobe fall gives next byte
// [R10] Random output command redirects read column
// [R11] At most four partial programs per page; the code counts only back-to-back programs to one page
// [R12] Program pages of a block in order
// [R13] Program is 80h, five addresses, data bytes
// [R14] Command 85h moves the load column
// [R15] Confirm 10h without loaded data is ignored
// [R16] Busy pin, status bit 6, pass bit 0
// [R17] Verify flags only failed 1-to-0 bits
// [R18] Status reads persist until next command
// [R19] Status command 70h polls during operations
// [R20] Write strobe rise latches command or address
// [R21] Busy pin low through every internal operation
`timescale 1ns/1ps
module nph_host
  import nph_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                       core_clk,      // Core clock, 100 MHz
  input  wire logic                       resetn,        // Async reset, active low
  input  wire logic                       cmd_valid,     // Operation request
  output logic                            cmd_ready,     // Sequencer idle
  input  wire nph_pkg::nph_op_t           cmd_op,        // Operation code
  input  wire logic [nph_pkg::COL_W-1:0]  cmd_col,       // Column address
  input  wire logic [nph_pkg::ROW_W-1:0]  cmd_row,       // Row address
  input  wire logic [nph_pkg::COL_W-1:0]  cmd_len,       // Byte count
  input  wire logic                       wr_valid,      // Program data offered
  output logic                            wr_ready,      // Program data taken
  input  wire logic [7:0]                 wr_data,       // Program data byte
  output logic                            rd_valid,      // Read byte pulse
  output logic [7:0]                      rd_data,       // Read byte
  output logic                            done,          // Operation finished
  output logic                            err,           // Finished with error
  output logic                            prog_fail,     // Last program failed
  output logic                            order_warn,    // Page loaded out of order
  output logic                            ce_n,          // Chip enable
  output logic                            cle,           // Command latch
  output logic                            ale,           // Address latch
  output logic                            we_n,          // Write strobe
  output logic                            read_strobe_n, // Read strobe
  output logic [7:0]                      io_out,        // Bus drive value
  output logic                            io_oe_n,       // Bus drive enable, low drives
  input  wire logic [7:0]                 io_in,         // Bus sample
  input  wire logic                       rb_n           // Ready/busy, low busy
);
  import nph_pkg::*;

  nph_state_t st_reg, st_next, succ;
  nph_phase_t ph_reg, ph_next;
  nph_op_t    op_reg;
  logic [COL_W-1:0] col_reg, len_reg, cnt_reg, cnt_next, tgt;
  logic [ROW_W-1:0] row_reg, load_row_reg, last_row_reg;
  logic [2:0] part_reg;
  logic       loaded_reg, tout_reg, fail_reg, done_reg, err_reg, warn_reg;
  logic       cap_reg, rdv_reg, ce_n_reg, cle_reg, ale_reg, we_n_reg, re_n_reg, oe_n_reg;
  logic [7:0] rdd_reg, io_out_reg;
  logic       tmr_load, tmr_done;
  logic [TMR_W-1:0] tmr_val, gap_val;
  logic       f_valid;
  logic [7:0] f_data;

  // Command, address and byte selection
  wire is_rd    = (op_reg == OP_READ);
  wire is_cf    = (op_reg == OP_CONFIRM);
  wire [7:0] cmd1_byte = (op_reg == OP_READ)     ? CMD_READ1 :     // [R6]
                         (op_reg == OP_RAND_OUT) ? CMD_RND_OUT1 :  // [R10]
                         (op_reg == OP_ID)       ? CMD_ID :        // [R3]
                         (op_reg == OP_STATUS)   ? CMD_STATUS :    // [R19]
                         (op_reg == OP_LOAD)     ? CMD_LOAD :      // [R13]
                         (op_reg == OP_RAND_IN)  ? CMD_RND_IN : CMD_PROG;
  wire [7:0] cmd2_byte = is_cf ? CMD_STATUS : is_rd ? CMD_READ2 : CMD_RND_OUT2;
  wire [2:0] n_addr = (is_rd || op_reg == OP_LOAD) ? ADDR_FULL :
                      (op_reg == OP_RAND_OUT || op_reg == OP_RAND_IN) ? ADDR_COL :
                      (op_reg == OP_ID) ? ADDR_ID : 3'h0;
  // Two column bytes, then three row bytes, low bits first [R2]
  wire [7:0] addr_byte = (op_reg == OP_ID)   ? ID_ADDR :
                         (cnt_reg[2:0] == 3'h0) ? col_reg[7:0] :
                         (cnt_reg[2:0] == 3'h1) ? {4'h0, col_reg[11:8]} :
                         (cnt_reg[2:0] == 3'h2) ? row_reg[7:0] :
                         (cnt_reg[2:0] == 3'h3) ? row_reg[15:8] :
                         {6'h00, row_reg[17:16]};
  wire [COL_W-1:0] rlen = (op_reg == OP_ID) ? ID_BYTES :
                          (op_reg == OP_STATUS || is_cf) ? 12'h001 : len_reg;
  wire [7:0] bus_byte = (st_reg == ST_CMD1) ? cmd1_byte :
                        (st_reg == ST_CMD2) ? cmd2_byte :
                        (st_reg == ST_ADDR) ? addr_byte : f_data;

  // Byte count of the current state and the state that follows it
  always_comb begin
    tgt  = '0;
    succ = ST_IDLE;
    case (st_reg)
      ST_CMD1: begin
        tgt  = 12'h001;
        succ = is_cf ? ST_BUSY : (op_reg == OP_STATUS) ? ST_RDATA : ST_ADDR;
      end
      ST_ADDR: begin
        tgt  = {9'h000, n_addr};
        succ = (op_reg == OP_LOAD || op_reg == OP_RAND_IN) ? ST_WDATA :
               (op_reg == OP_ID) ? ST_RDATA : ST_CMD2;
      end
      ST_WDATA: begin
        tgt  = len_reg;
        succ = ST_IDLE;
      end
      ST_CMD2: begin
        tgt  = 12'h001;
        succ = is_rd ? ST_BUSY : ST_RDATA;
      end
      ST_BUSY: begin
        succ = is_cf ? ST_CMD2 : ST_RDATA; // Program is followed by a 70h poll [R19]
      end
      ST_RDATA: begin
        tgt  = rlen;
        succ = ST_IDLE;
      end
      default: begin
        tgt  = '0;
        succ = ST_IDLE;
      end
    endcase
  end

  // Entry wait of the next state: address-to-data, write-to-read, write-to-busy
  assign gap_val = (succ == ST_WDATA) ? TMR_W'(ADL_CYC - 1) :
                   (succ == ST_RDATA) ? TMR_W'(WHR_CYC - 1) :
                   (succ == ST_BUSY)  ? TMR_W'(WB_CYC - 1) : '0;

  // Request screening; a lone confirm would start nothing in the device
  wire lim_hit  = (load_row_reg == last_row_reg) && (part_reg == MAX_PARTIAL); // [R11]
  wire refuse   = (cmd_op == OP_NONE) ||
                  (cmd_op == OP_CONFIRM && (!loaded_reg || lim_hit));            // [R15]
  wire take     = cmd_valid && cmd_ready;
  wire start    = take && !refuse;
  wire in_bus   = (st_reg != ST_IDLE) && (st_reg != ST_BUSY);
  wire drv      = in_bus && (st_reg != ST_RDATA);
  wire gap_done = in_bus && (ph_reg == PH_GAP) && tmr_done;
  wire adv      = gap_done && (cnt_reg == tgt);
  wire go_low   = gap_done && (cnt_reg != tgt) && ((st_reg != ST_WDATA) || f_valid);
  wire f_pop    = go_low && (st_reg == ST_WDATA);
  // No data yet: release chip enable, the device keeps its page register [R1]
  wire ce_drop  = gap_done && (cnt_reg != tgt) && (st_reg == ST_WDATA) && !f_valid;
  wire busy_out = (st_reg == ST_BUSY) && (ph_reg == PH_LOW) && rb_n;            // [R21]
  wire finish   = (adv || busy_out) && (succ == ST_IDLE);
  wire tout     = (st_reg == ST_BUSY) && (ph_reg == PH_LOW) && tmr_done && !rb_n && is_rd;

  assign cmd_ready = (st_reg == ST_IDLE);

  // Sequencer: gap, strobe low, strobe high for every byte
  always_comb begin
    st_next  = st_reg;
    ph_next  = ph_reg;
    cnt_next = cnt_reg;
    tmr_load = 1'b0;
    tmr_val  = '0;
    if (st_reg == ST_IDLE) begin
      if (start) begin
        st_next  = ST_CMD1;
        ph_next  = PH_GAP;
        cnt_next = '0;
        tmr_load = 1'b1;
      end
    end else if (st_reg == ST_BUSY) begin
      if (ph_reg == PH_GAP && tmr_done) begin
        ph_next  = PH_LOW;
        tmr_load = 1'b1;
        tmr_val  = TMR_W'(TR_CYC - 1); // Page transfer limit [R8]
      end else if (busy_out) begin
        st_next  = succ;
        ph_next  = PH_GAP;
        cnt_next = '0;
        tmr_load = 1'b1;
        tmr_val  = gap_val;
      end
    end else if (adv) begin
      st_next  = succ;
      ph_next  = PH_GAP;
      cnt_next = '0;
      tmr_load = 1'b1;
      tmr_val  = gap_val;
    end else if (go_low) begin
      ph_next  = PH_LOW;
      tmr_load = 1'b1;
      tmr_val  = TMR_W'(LOW_CYC - 1);
    end else if (ph_reg == PH_LOW && tmr_done) begin
      ph_next  = PH_HIGH;
      tmr_load = 1'b1;
      tmr_val  = TMR_W'(HIGH_CYC - 1);
    end else if (ph_reg == PH_HIGH && tmr_done) begin
      ph_next  = PH_GAP;
      cnt_next = cnt_reg + 1'b1;
      tmr_load = 1'b1;
    end
  end

  nph_timer #(.W(TMR_W)) u_timer (
    .clk      (core_clk),
    .resetn   (resetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // Program data queue; a stalled bus backs up into wr_ready
  nph_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (core_clk),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // Sequencer state and latched request
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg  <= ST_IDLE;
      ph_reg  <= PH_GAP;
      cnt_reg <= '0;
      op_reg  <= OP_NONE;
      col_reg <= '0;
      row_reg <= '0;
      len_reg <= '0;
    end else begin
      st_reg  <= st_next;
      ph_reg  <= ph_next;
      cnt_reg <= cnt_next;
      if (start) begin
        op_reg  <= cmd_op;
        col_reg <= cmd_col;
        row_reg <= cmd_row;
        len_reg <= cmd_len;
      end
    end
  end

  // Page bookkeeping: load state, partial count, order check
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      loaded_reg   <= 1'b0;
      load_row_reg <= '0;
      last_row_reg <= '1;
      part_reg     <= '0;
      warn_reg     <= 1'b0;
    end else begin
      warn_reg <= 1'b0;
      if (f_pop) begin
        loaded_reg <= 1'b1;  // [R13]
      end else if (start && (cmd_op == OP_CONFIRM || cmd_op == OP_READ)) begin
        loaded_reg <= 1'b0;
      end
      if (start && cmd_op == OP_LOAD) begin
        load_row_reg <= cmd_row;
        warn_reg <= (cmd_row[ROW_W-1:PAGE_BITS] == last_row_reg[ROW_W-1:PAGE_BITS]) &&
                    (cmd_row[PAGE_BITS-1:0] < last_row_reg[PAGE_BITS-1:0]); // [R12]
      end
      if (start && cmd_op == OP_CONFIRM) begin
        last_row_reg <= load_row_reg;
        part_reg <= (load_row_reg == last_row_reg) ? part_reg + 1'b1 : 3'h1; // [R11]
      end
    end
  end

  // Read capture, result flags; io_in is taken one cycle after the strobe phase ends
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cap_reg  <= 1'b0;
      rdv_reg  <= 1'b0;
      rdd_reg  <= '0;
      fail_reg <= 1'b0;
      tout_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      cap_reg  <= (st_reg == ST_RDATA) && (ph_reg == PH_LOW) && tmr_done; // [R9]
      rdv_reg  <= cap_reg;
      done_reg <= finish || (take && refuse);
      err_reg  <= (finish && (tout_reg || tout)) || (take && refuse);
      if (cap_reg) begin
        rdd_reg <= io_in;
      end
      if (cap_reg && is_cf) begin
        fail_reg <= io_in[ST_PASS_BIT]; // [R16]
      end
      if (start) begin
        tout_reg <= 1'b0;
      end else if (tout) begin
        tout_reg <= 1'b1; // [R8]
      end
    end
  end

  // Pin drivers, one register each
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ce_n_reg   <= 1'b1;
      cle_reg    <= 1'b0;
      ale_reg    <= 1'b0;
      we_n_reg   <= 1'b1;
      re_n_reg   <= 1'b1;
      oe_n_reg   <= 1'b1;
      io_out_reg <= '0;
    end else begin
      ce_n_reg <= (st_reg == ST_IDLE) || ce_drop;                     // [R1]
      cle_reg  <= (st_reg == ST_CMD1) || (st_reg == ST_CMD2);         // [R20]
      ale_reg  <= (st_reg == ST_ADDR);                                // [R20]
      we_n_reg <= !(drv && ph_reg == PH_LOW);                         // [R20]
      re_n_reg <= !(st_reg == ST_RDATA && ph_reg == PH_LOW);          // [R9]
      oe_n_reg <= !drv;
      if (go_low && drv) begin
        io_out_reg <= bus_byte;
      end
    end
  end

  assign ce_n          = ce_n_reg;
  assign cle           = cle_reg;
  assign ale           = ale_reg;
  assign we_n          = we_n_reg;
  assign read_strobe_n = re_n_reg;
  assign io_oe_n       = oe_n_reg;
  assign io_out        = io_out_reg;
  assign rd_valid      = rdv_reg;
  assign rd_data       = rdd_reg;
  assign done          = done_reg;
  assign err           = err_reg;
  assign prog_fail     = fail_reg;
  assign order_warn    = warn_reg;

  // Helper counts of latched address bytes and read strobes
  logic [3:0] ale_cnt_reg, re_cnt_reg;
  wire        we_n_next_hi = !(drv && ph_reg == PH_LOW);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ale_cnt_reg <= '0;
      re_cnt_reg  <= '0;
    end else if (st_reg == ST_CMD1) begin
      ale_cnt_reg <= '0;
      re_cnt_reg  <= '0;
    end else begin
      if (!we_n_reg && we_n_next_hi && ale_reg) ale_cnt_reg <= ale_cnt_reg + 1'b1;
      if (!re_n_reg && !(st_reg == ST_RDATA && ph_reg == PH_LOW)) re_cnt_reg <= re_cnt_reg + 1'b1;
    end
  end
  property p_we_ctl;
    @(posedge core_clk) disable iff (!resetn)
      $fell(we_n_reg) |-> !ce_n_reg && !(cle_reg && ale_reg) && !oe_n_reg;
  endproperty
  a_we_ctl: assert property (p_we_ctl) else $error("write strobe without enable"); // [R20]

  property p_we_width;
    @(posedge core_clk) disable iff (!resetn)
      $fell(we_n_reg) |-> !we_n_reg[*3] ##1 we_n_reg;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong"); // [R20]

  property p_five_addr;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg == ST_CMD2 && $past(st_reg) == ST_ADDR && op_reg == OP_READ) |-> ale_cnt_reg == 4'h5;
  endproperty
  a_five_addr: assert property (p_five_addr) else $error("read address not five bytes"); // [R2]

  property p_read_cmd;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg == ST_CMD2 && $past(st_reg) == ST_ADDR && op_reg == OP_READ)
        |-> ##[1:20] (!we_n_reg && cle_reg && io_out_reg == 8'h30) ##[1:20] st_reg == ST_BUSY;
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("read confirm missing"); // [R6]

  property p_id_four;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg == ST_IDLE && $past(st_reg) == ST_RDATA && op_reg == OP_ID) |-> re_cnt_reg == 4'h4;
  endproperty
  a_id_four: assert property (p_id_four) else $error("id read not four bytes"); // [R3]

  property p_lone_confirm;
    @(posedge core_clk) disable iff (!resetn)
      (take && cmd_op == OP_CONFIRM && !loaded_reg) |=> done_reg && err_reg && st_reg == ST_IDLE;
  endproperty
  a_lone_confirm: assert property (p_lone_confirm) else $error("confirm without data"); // [R15]

  property p_partial;
    @(posedge core_clk) disable iff (!resetn)
      (take && cmd_op == OP_CONFIRM && lim_hit) |=> err_reg && st_reg == ST_IDLE;
  endproperty
  a_partial: assert property (p_partial) else $error("partial program limit passed"); // [R11]

  property p_ce_drop;
    @(posedge core_clk) disable iff (!resetn)
      ce_drop |=> ce_n_reg && we_n_reg;
  endproperty
  a_ce_drop: assert property (p_ce_drop) else $error("enable held while starved"); // [R1]

  property p_status_poll;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg == ST_CMD2 && $past(st_reg) == ST_BUSY)
        |-> ##[1:10] (!we_n_reg && cle_reg && io_out_reg == 8'h70);
  endproperty
  a_status_poll: assert property (p_status_poll) else $error("no status poll"); // [R19]

  property p_data_drive;
    @(posedge core_clk) disable iff (!resetn)
      (!we_n_reg && st_reg == ST_WDATA) |-> !oe_n_reg && !cle_reg && !ale_reg;
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("data byte badly framed"); // [R13]

  c_read: cover property (@(posedge core_clk) done_reg && op_reg == OP_READ && !err_reg);
  c_prog: cover property (@(posedge core_clk) done_reg && op_reg == OP_CONFIRM && !err_reg);
  c_id:   cover property (@(posedge core_clk) done_reg && op_reg == OP_ID);
  c_ce:   cover property (@(posedge core_clk) ce_drop);
endmodule

// ---- nph_flash_model.sv ----
`timescale 1ns/1ps
module nph_flash_model #(
  parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEV   = 8'ha7  // Arbitrary value
) (
  input  wire logic       ce_n,          // Chip enable
  input  wire logic       cle,           // Command latch
  input  wire logic       ale,           // Address latch
  input  wire logic       we_n,          // Write strobe
  input  wire logic       read_strobe_n, // Read strobe
  input  wire logic [7:0] io_out,        // Host drive value
  input  wire logic       io_oe_n,       // Host drives when low
  output logic      [7:0] io_in,         // Device drive value
  output logic            rb_n           // Ready/busy
);
  logic [7:0]  pg [0:4095];
  logic [7:0]  mode;
  logic [11:0] col;
  logic [2:0]  na;
  logic        ld;
  initial begin
    foreach (pg[i]) pg[i] = 8'hff;
    {rb_n, mode, col, na, ld, io_in} = {1'b1, 8'h00, 12'h000, 3'h0, 1'b0, 8'h5a};
  end
  // Write strobe rise latches command, address or data
  always @(posedge we_n) if (!ce_n && !io_oe_n) begin
    if (cle) begin
      mode = io_out;
      na = 3'h0;
      if (io_out == 8'h90) col = 12'h000;
      if (io_out == 8'h80) ld = 1'b0;
      if (io_out == 8'h30 || (io_out == 8'h10 && ld)) begin
        rb_n = 1'b0;
        #300 rb_n = 1'b1;
      end
    end else if (ale) begin
      if (na == 3'h0) col[7:0] = io_out;
      if (na == 3'h1) col[11:8] = io_out[3:0];
      na = na + 3'h1;
    end else if (mode == 8'h80 || mode == 8'h85) begin
      pg[col] = io_out;
      col = col + 12'h001;
      ld = 1'b1;
    end
  end
  // Each strobe fall shows a byte; the bus goes stale after hold time
  always @(negedge read_strobe_n) begin
    if (mode == 8'h70) io_in = {1'b1, rb_n, rb_n, 5'h00};
    else if (mode == 8'h90) io_in = col[1:0] == 2'h0 ? MAKER : col[1:0] == 2'h1 ? DEV :
                                    col[1:0] == 2'h2 ? 8'h00 : 8'h95;
    else io_in = pg[col];
    if (mode != 8'h70) col = col + 12'h001;
  end
  always @(posedge read_strobe_n) #15 io_in = ~io_in;
endmodule

// ---- test_nph_host.sv ----
`timescale 1ns/1ps
module test_nph_host;
  import nph_pkg::*;
  logic core_clk, resetn, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done, err;
  logic prog_fail, order_warn, ce_n, cle, ale, we_n, read_strobe_n, io_oe_n, rb_n;
  nph_op_t     cmd_op;
  logic [11:0] cmd_col, cmd_len;
  logic [17:0] cmd_row;
  logic [7:0]  wr_data, rd_data, io_out, io_in;
  logic [7:0]  exp_q[$], dat[$];
  logic        err_q[$];
  int          miscompares, checked, seed, n, k, i;
  bit          wseen;
  nph_host uut (.core_clk, .resetn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_col, .cmd_row,
    .cmd_len, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data, .done, .err, .prog_fail,
    .order_warn, .ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_out, .io_oe_n, .io_in, .rb_n);
  nph_flash_model dev (.ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_out, .io_oe_n, .io_in,
    .rb_n);
  task automatic give_verdict();
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One request, then a bounded wait for its done pulse
  task automatic op(input nph_op_t o, input logic [11:0] c, input logic [11:0] l, input logic e);
    err_q.push_back(e);
    cmd_op = o;
    {cmd_col, cmd_len, cmd_valid} = {c, l, 1'b1};
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    for (k = 0; k < 9000 && !done; k++) @(posedge core_clk);
    if (k == 9000) begin
      miscompares++;
      give_verdict();
    end
    #1;
  endtask
  // One program byte into the buffer
  task automatic put();
    {wr_data, wr_valid} = {8'($random(seed)), 1'b1};
    @(posedge core_clk);
    #1 wr_valid = 1'b0;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Results are matched against the oldest note as they appear
  always @(posedge core_clk) begin
    if (order_warn) wseen = 1'b1;
    if (rd_valid) cmp(rd_data, exp_q.pop_front());
    if (done) cmp({7'h00, err}, {7'h00, err_q.pop_front()});
  end
  initial begin
    seed = 34;
    {resetn, cmd_valid, wr_valid, cmd_col, cmd_len, wr_data} = '0;
    cmd_op = OP_NONE;
    // Top page of a random block, so a later load to page 0 is out of order
    cmd_row = {12'($random(seed)), 6'h3f};
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    op(OP_CONFIRM, 12'h000, 12'h000, 1'b1);
    op(OP_NONE, 12'h000, 12'h000, 1'b1);
    // Fill the buffer until it refuses, then program what was stored
    while (wr_ready && n < 40) begin
      wr_data = 8'($random(seed));
      wr_valid = 1'b1;
      dat.push_back(wr_data);
      @(posedge core_clk);
      #1 n++;
    end
    wr_valid = 1'b0;
    op(OP_LOAD, 12'h010, 12'(n), 1'b0);
    cmp({7'h00, wseen}, 8'h00);
    exp_q.push_back(8'he0);
    op(OP_CONFIRM, 12'h000, 12'h000, 1'b0);
    cmp({7'h00, prog_fail}, 8'h00);
    foreach (dat[i]) exp_q.push_back(dat[i]);
    op(OP_READ, 12'h010, 12'(n), 1'b0);
    exp_q.push_back(dat[3]);
    exp_q.push_back(dat[4]);
    op(OP_RAND_OUT, 12'h013, 12'h002, 1'b0);
    exp_q = {exp_q, 8'h3c, 8'ha7, 8'h00, 8'h95};
    op(OP_ID, 12'h000, 12'h004, 1'b0);
    exp_q.push_back(8'he0);
    op(OP_STATUS, 12'h000, 12'h000, 1'b0);
    // Three more programs reach the partial limit of the page, the fourth is refused;
    // the first one waits for its second byte with chip enable released
    for (i = 0; i < 4; i++) begin
      put();
      fork
        op(OP_LOAD, 12'h800, 12'(1 + (i == 0)), 1'b0);
        if (i == 0) begin
          repeat (80) @(posedge core_clk);
          #1 put();
        end
      join
      if (i < 3) exp_q.push_back(8'he0);
      op(OP_CONFIRM, 12'h000, 12'h000, i == 3);
    end
    cmd_row[5:0] = 6'h00;
    op(OP_LOAD, 12'h000, 12'h000, 1'b0);
    cmp({7'h00, wseen}, 8'h01);
    cmp(8'(exp_q.size() + err_q.size()), 8'h00);
    give_verdict();
  end
endmodule
